// *** design/csk_skip_core.v ***
// Contract
// [RULE_01] Polarity 0: pin-b skip skips when pin low, executes next when high.
// [RULE_02] Polarity 1: pin-b skip skips when pin high, executes next when low.
// [RULE_03] Pin-b skip decodes from 0x03B, one word, one cycle, carry untouched.
// [RULE_04] Powerdown skip skips when powerdown flag is 1, else executes next.
// [RULE_05] Powerdown skip never changes the powerdown flag.
// [RULE_06] Timer1 enable 0: opcode 0x280 clears set timer1 flag and skips; a same-cycle I_TIMER1_SET keeps the flag set.
// [RULE_07] Timer1 enable 1: timer1 skip is a no-operation, flag untouched.
// [RULE_08] Timer1 enable lives at bit 2 of interrupt control register A.
// [RULE_09] A skipped instruction is discarded and changes no state.
`timescale 1ns/1ps
`include "csk_skip_map.vh"

module csk_skip_core
(
   // Clock and reset
   input wire I_CORE_CLK,
   input wire I_RESET,
   // AHB-Lite slave
   input wire I_HSEL,
   input wire [31:0] I_HADDR,
   input wire [1:0] I_HTRANS,
   input wire I_HWRITE,
   input wire [2:0] I_HSIZE,
   input wire [31:0] I_HWDATA,
   input wire I_HREADY,
   output wire [31:0] O_HRDATA,
   output wire O_HREADYOUT,
   output wire O_HRESP,
   // Instruction from sequencer
   input wire I_INSTR_VALID,
   input wire [`CSK_INSTR_W-1:0] I_INSTR,
   // Flag and pin sources
   input wire I_EXTERNAL_INTERRUPT_PIN_B,
   input wire I_POWERDOWN_FLAG,
   input wire I_TIMER1_SET,
   // Answers to sequencer
   output wire O_SKIP,
   output wire O_DONE,
   output wire O_SUPPRESSED,
   output wire O_TIMER1_REQUEST_FLAG,
   // Interrupt
   output wire O_IRQ
);

// ----------------------------------------
// Declarations
// ----------------------------------------
wire pin_b_sync;
wire wr_en;
wire [`CSK_ADDR_W-1:0] reg_addr;
wire [31:0] reg_wdata;
reg [31:0] reg_rdata;

reg pin_b_polarity_select_reg;
reg [`CSK_INTCTL_A_W-1:0] interrupt_control_reg_a_reg;
reg timer1_request_flag_reg;
reg timer1_request_flag_next;
reg skip_pend_reg;
reg skip_pend_next;
reg [`CSK_IRQ_W-1:0] irq_stat_reg;
reg [`CSK_IRQ_W-1:0] irq_stat_next;
reg [`CSK_IRQ_W-1:0] irq_mask_reg;
reg skip_reg;
reg done_reg;
reg suppressed_reg;
reg irq_reg;

wire timer1_interrupt_enable;
wire executing;
wire discarding;
wire skip_on_ext_pin1_level;
wire skip_on_powerdown_flag;
wire skip_on_timer1_request;
wire pin_b_hit;
wire timer1_hit;
wire skip_take;
wire [`CSK_IRQ_W-1:0] irq_events;
wire [`CSK_IRQ_W-1:0] irq_clear;
wire wr_ctrl;
wire wr_intctl_a;
wire wr_irq_stat;
wire wr_irq_mask;
reg skip_next;
reg done_next;
reg suppressed_next;
reg irq_next;

// ----------------------------------------
// Pin synchroniser
// ----------------------------------------
csk_sync u_pin_sync
(
   .i_clk(I_CORE_CLK),
   .i_reset(I_RESET),
   .i_async(I_EXTERNAL_INTERRUPT_PIN_B),
   .o_sync(pin_b_sync)
);

// ----------------------------------------
// Bus slave
// ----------------------------------------
csk_ahb_slave u_ahb
(
   .i_clk(I_CORE_CLK),
   .i_reset(I_RESET),
   .i_hsel(I_HSEL),
   .i_haddr(I_HADDR),
   .i_htrans(I_HTRANS),
   .i_hwrite(I_HWRITE),
   .i_hsize(I_HSIZE),
   .i_hwdata(I_HWDATA),
   .i_hready(I_HREADY),
   .o_hrdata(O_HRDATA),
   .o_hreadyout(O_HREADYOUT),
   .o_hresp(O_HRESP),
   .o_wr_en(wr_en),
   .o_addr(reg_addr),
   .o_wdata(reg_wdata),
   .i_rdata(reg_rdata)
);

// ----------------------------------------
// Register write strobes
// ----------------------------------------
// Status offset is read-only, so it has no strobe
assign wr_ctrl = wr_en & (reg_addr == `CSK_OFS_CTRL);
assign wr_intctl_a = wr_en & (reg_addr == `CSK_OFS_INTCTL_A);
assign wr_irq_stat = wr_en & (reg_addr == `CSK_OFS_IRQ_STAT);
assign wr_irq_mask = wr_en & (reg_addr == `CSK_OFS_IRQ_MASK);

// ----------------------------------------
// Instruction decode
// ----------------------------------------
// [RULE_08] enable bit position
assign timer1_interrupt_enable = interrupt_control_reg_a_reg[`CSK_T1_EN_BIT];

// [RULE_09] discard after taken skip
assign executing = I_INSTR_VALID & ~skip_pend_reg;
assign discarding = I_INSTR_VALID & skip_pend_reg;

// [RULE_03] pin-b opcode decode
assign skip_on_ext_pin1_level = executing & (I_INSTR == `CSK_OP_PIN_B);
assign skip_on_powerdown_flag = executing & (I_INSTR == `CSK_OP_POWERDOWN);
// [RULE_06] timer1 opcode decode
assign skip_on_timer1_request = executing & (I_INSTR == `CSK_OP_TIMER1);

// [RULE_01] low-level skip
// [RULE_02] high-level skip
assign pin_b_hit = pin_b_polarity_select_reg ? pin_b_sync : ~pin_b_sync;

// [RULE_07] enable set means no-op
assign timer1_hit = skip_on_timer1_request & ~timer1_interrupt_enable & timer1_request_flag_reg;

// [RULE_04] powerdown flag test
assign skip_take = (skip_on_ext_pin1_level & pin_b_hit)
   | (skip_on_powerdown_flag & I_POWERDOWN_FLAG)
   | timer1_hit;

// ----------------------------------------
// Timer1 flag and skip tracking
// ----------------------------------------
always @*
begin
   timer1_request_flag_next = timer1_request_flag_reg;
   // [RULE_06] clear on tested hit
   if (timer1_hit)
      timer1_request_flag_next = 1'h0;
   // New request wins over clear
   if (I_TIMER1_SET)
      timer1_request_flag_next = 1'h1;
end

always @*
begin
   skip_pend_next = skip_pend_reg;
   // [RULE_09] one instruction dropped
   if (discarding)
      skip_pend_next = 1'h0;
   else if (skip_take)
      skip_pend_next = 1'h1;
end

// ----------------------------------------
// Interrupt status
// ----------------------------------------
assign irq_events = {discarding, I_TIMER1_SET & ~timer1_request_flag_reg, skip_take};
assign irq_clear = wr_irq_stat ? reg_wdata[`CSK_IRQ_W-1:0] : {`CSK_IRQ_W{1'b0}};

always @*
begin
   irq_stat_next = (irq_stat_reg & ~irq_clear) | irq_events;
end

// ----------------------------------------
// Output pulses
// ----------------------------------------
always @*
begin
   // [RULE_03] one-cycle completion
   skip_next = skip_take;
   done_next = skip_on_ext_pin1_level | skip_on_powerdown_flag | skip_on_timer1_request;
   suppressed_next = discarding;
   // Built from next status, so no extra cycle of lag
   irq_next = |(irq_stat_next & irq_mask_reg);
end

// ----------------------------------------
// Control registers
// ----------------------------------------
always @(posedge I_CORE_CLK)
begin
   if (I_RESET)
   begin
      pin_b_polarity_select_reg <= `CSK_RST_POL;
      interrupt_control_reg_a_reg <= `CSK_RST_INTCTL_A;
      irq_mask_reg <= `CSK_RST_IRQ_MASK;
   end
   else
   begin
      if (wr_ctrl)
         pin_b_polarity_select_reg <= reg_wdata[`CSK_CTRL_POL_BIT];
      // [RULE_08] enable field write
      if (wr_intctl_a)
         interrupt_control_reg_a_reg <= reg_wdata[`CSK_INTCTL_A_W-1:0];
      if (wr_irq_mask)
         irq_mask_reg <= reg_wdata[`CSK_IRQ_W-1:0];
   end
end

// ----------------------------------------
// Sequential state
// ----------------------------------------
always @(posedge I_CORE_CLK)
begin
   if (I_RESET)
   begin
      timer1_request_flag_reg <= 1'h0;
      skip_pend_reg <= 1'h0;
      irq_stat_reg <= {`CSK_IRQ_W{1'b0}};
   end
   else
   begin
      timer1_request_flag_reg <= timer1_request_flag_next;
      skip_pend_reg <= skip_pend_next;
      irq_stat_reg <= irq_stat_next;
   end
end

// ----------------------------------------
// Output registers
// ----------------------------------------
always @(posedge I_CORE_CLK)
begin
   if (I_RESET)
   begin
      skip_reg <= 1'h0;
      done_reg <= 1'h0;
      suppressed_reg <= 1'h0;
      irq_reg <= 1'h0;
   end
   else
   begin
      skip_reg <= skip_next;
      done_reg <= done_next;
      suppressed_reg <= suppressed_next;
      irq_reg <= irq_next;
   end
end

// ----------------------------------------
// Register read
// ----------------------------------------
always @*
begin
   reg_rdata = 32'h00000000;
   case (reg_addr)
      `CSK_OFS_CTRL:
      begin
         reg_rdata[`CSK_CTRL_POL_BIT] = pin_b_polarity_select_reg;
      end
      `CSK_OFS_INTCTL_A:
      begin
         reg_rdata[`CSK_INTCTL_A_W-1:0] = interrupt_control_reg_a_reg;
      end
      `CSK_OFS_STATUS:
      begin
         reg_rdata[`CSK_ST_T1F_BIT] = timer1_request_flag_reg;
         reg_rdata[`CSK_ST_PIN_BIT] = pin_b_sync;
         // [RULE_05] flag only observed
         reg_rdata[`CSK_ST_PD_BIT] = I_POWERDOWN_FLAG;
         reg_rdata[`CSK_ST_PEND_BIT] = skip_pend_reg;
      end
      `CSK_OFS_IRQ_STAT:
      begin
         reg_rdata[`CSK_IRQ_W-1:0] = irq_stat_reg;
      end
      `CSK_OFS_IRQ_MASK:
      begin
         reg_rdata[`CSK_IRQ_W-1:0] = irq_mask_reg;
      end
      default:
      begin
         reg_rdata = 32'h00000000;
      end
   endcase
end

// ----------------------------------------
// Outputs
// ----------------------------------------
assign O_SKIP = skip_reg;
assign O_DONE = done_reg;
assign O_SUPPRESSED = suppressed_reg;
assign O_TIMER1_REQUEST_FLAG = timer1_request_flag_reg;
assign O_IRQ = irq_reg;

endmodule // csk_skip_core

// *** common/csk_skip_map.vh ***
`ifndef CSK_SKIP_MAP_VH
`define CSK_SKIP_MAP_VH

// ----------------------------------------
// Instruction encodings (10-bit words)
// ----------------------------------------
`define CSK_INSTR_W 10
`define CSK_OP_PIN_B 10'h03B
`define CSK_OP_POWERDOWN 10'h003
`define CSK_OP_TIMER1 10'h280

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CSK_ADDR_W 8
`define CSK_OFS_CTRL 8'h00
`define CSK_OFS_INTCTL_A 8'h04
`define CSK_OFS_STATUS 8'h08
`define CSK_OFS_IRQ_STAT 8'h0C
`define CSK_OFS_IRQ_MASK 8'h10

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define CSK_CTRL_POL_BIT 0
`define CSK_INTCTL_A_W 4
`define CSK_T1_EN_BIT 2
`define CSK_ST_T1F_BIT 0
`define CSK_ST_PIN_BIT 1
`define CSK_ST_PD_BIT 2
`define CSK_ST_PEND_BIT 3
`define CSK_IRQ_W 3
`define CSK_IRQ_SKIP_BIT 0
`define CSK_IRQ_T1SET_BIT 1
`define CSK_IRQ_SUPPR_BIT 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSK_RST_POL 1'h0
`define CSK_RST_INTCTL_A 4'h0
`define CSK_RST_IRQ_MASK 3'h0

`endif

// *** design/csk_sync.v ***
`timescale 1ns/1ps

// ----------------------------------------
// Two-flop level synchroniser
// ----------------------------------------
module csk_sync
(
   // Clock and reset
   input wire i_clk,
   input wire i_reset,
   // Data
   input wire i_async,
   output wire o_sync
);

reg stage1_reg;
reg stage2_reg;

always @(posedge i_clk)
begin
   if (i_reset)
   begin
      stage1_reg <= 1'h0;
      stage2_reg <= 1'h0;
   end
   else
   begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
   end
end

assign o_sync = stage2_reg;

endmodule // csk_sync

// *** design/csk_ahb_slave.v ***
`timescale 1ns/1ps
`include "csk_skip_map.vh"

// ----------------------------------------
// AHB-Lite slave, one wait state per transfer
// ----------------------------------------
module csk_ahb_slave
(
   // Clock and reset
   input wire i_clk,
   input wire i_reset,
   // AHB-Lite
   input wire i_hsel,
   input wire [31:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [2:0] i_hsize,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   output wire [31:0] o_hrdata,
   output wire o_hreadyout,
   output wire o_hresp,
   // Register side
   output wire o_wr_en,
   output wire [`CSK_ADDR_W-1:0] o_addr,
   output wire [31:0] o_wdata,
   input wire [31:0] i_rdata
);

reg pend_reg;
reg write_reg;
reg [`CSK_ADDR_W-1:0] addr_reg;
reg [31:0] hrdata_reg;
reg hreadyout_reg;
reg hresp_reg;
wire accept;

// Only whole-word accesses occur; hsize is not checked
assign accept = i_hsel & i_htrans[1] & i_hready;

always @(posedge i_clk)
begin
   if (i_reset)
   begin
      pend_reg <= 1'h0;
      write_reg <= 1'h0;
      addr_reg <= {`CSK_ADDR_W{1'b0}};
      hrdata_reg <= 32'h00000000;
      hreadyout_reg <= 1'h1;
      hresp_reg <= 1'h0;
   end
   else if (pend_reg)
   begin
      pend_reg <= 1'h0;
      hreadyout_reg <= 1'h1;
      if (!write_reg)
         hrdata_reg <= i_rdata;
   end
   else if (accept)
   begin
      pend_reg <= 1'h1;
      write_reg <= i_hwrite;
      addr_reg <= {i_haddr[`CSK_ADDR_W-1:2], 2'h0};
      hreadyout_reg <= 1'h0;
   end
end

assign o_wr_en = pend_reg & write_reg;
assign o_addr = addr_reg;
assign o_wdata = i_hwdata;
assign o_hrdata = hrdata_reg;
assign o_hreadyout = hreadyout_reg;
assign o_hresp = hresp_reg;

endmodule // csk_ahb_slave

// *** dv/csk_seq_model.sv ***
`timescale 1ns/1ps

// ----
// Sequencer: one strobe per request
// ----
module csk_seq_model
(
   // Clock
   input wire i_clk,
   // Request from bench
   input wire i_go,
   input wire [9:0] i_op,
   // To core
   output reg o_valid,
   output reg [9:0] o_instr
);
   initial
   begin
      o_valid = 1'b0;
      o_instr = 10'h000;
   end

   always @(posedge i_clk)
   begin
      o_valid <= i_go;
      // Word toggles while no strobe is up
      o_instr <= i_go ? i_op : ~o_instr;
   end
endmodule // csk_seq_model

// *** dv/csk_skip_checker.sv ***
`timescale 1ns/1ps

// ----
// Port checks
// ----
module csk_skip_checker
(
   // Clock and reset
   input wire I_CORE_CLK,
   input wire I_RESET,
   // Watched ports
   input wire I_INSTR_VALID,
   input wire [9:0] I_INSTR,
   input wire I_POWERDOWN_FLAG,
   input wire I_TIMER1_SET,
   input wire O_SKIP,
   input wire O_DONE,
   input wire O_SUPPRESSED,
   input wire O_TIMER1_REQUEST_FLAG,
   input wire O_HREADYOUT,
   input wire O_HRESP
);
   reg pend_reg;
   wire pend = O_SKIP | pend_reg;
   wire fresh = I_INSTR_VALID & ~pend;
   wire t1 = fresh && I_INSTR == 10'h280;

   always @(posedge I_CORE_CLK)
      pend_reg <= I_RESET ? 1'b0 : pend & ~I_INSTR_VALID;

   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RESET);

   a_pd_skip:
      assert property (fresh && I_INSTR == 10'h003 |=> O_DONE && O_SKIP == $past(I_POWERDOWN_FLAG))
      else $error("powerdown skip wrong");
   a_t1_clear:
      assert property (t1 && O_TIMER1_REQUEST_FLAG && !I_TIMER1_SET |=> O_DONE && O_SKIP != O_TIMER1_REQUEST_FLAG)
      else $error("timer1 test wrong");
   a_t1_empty:
      assert property (t1 && !O_TIMER1_REQUEST_FLAG |=> O_DONE && !O_SKIP)
      else $error("timer1 empty skipped");
   a_skip_discard:
      assert property (I_INSTR_VALID && pend |=> O_SUPPRESSED && !O_DONE && !O_SKIP)
      else $error("skipped word not discarded");
   a_other_op:
      assert property (fresh && I_INSTR != 10'h03B && I_INSTR != 10'h003 && I_INSTR != 10'h280
         |=> !O_DONE && !O_SKIP)
      else $error("foreign opcode decoded");
   a_idle_quiet:
      assert property (!I_INSTR_VALID |=> !O_DONE && !O_SUPPRESSED && !O_SKIP)
      else $error("pulse without strobe");
   a_flag_set:
      assert property (I_TIMER1_SET |=> O_TIMER1_REQUEST_FLAG)
      else $error("timer1 flag not set");
   a_flag_hold:
      assert property (!I_TIMER1_SET && !t1 |=> O_TIMER1_REQUEST_FLAG == $past(O_TIMER1_REQUEST_FLAG))
      else $error("timer1 flag moved");
   a_one_wait:
      assert property ($fell(O_HREADYOUT) |=> O_HREADYOUT)
      else $error("wait state too long");
   a_okay_resp:
      assert property (O_HRESP == 1'b0)
      else $error("response not okay");
endmodule // csk_skip_checker

// *** dv/csk_skip_core_tb.sv ***
`timescale 1ns/1ps

// ----
// Bench
// ----
module csk_skip_core_tb;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [31:0] haddr = 32'h0;
   reg [1:0] htrans = 2'h0;
   reg hwrite = 1'b0;
   reg [31:0] hwdata = 32'h0;
   reg pin = 1'b1;
   reg pd = 1'b0;
   reg tset = 1'b0;
   reg go = 1'b0;
   reg [9:0] op = 10'h0;
   wire [31:0] hrdata;
   wire hready, valid, skip, done, supp, t1f, irq;
   wire [9:0] instr;
   reg [31:0] r;
   integer n_mismatch = 0;
   integer cmp_count = 0;
   integer p, v;

   always #4 clk = ~clk;

   csk_seq_model seq_u (.i_clk(clk), .i_go(go), .i_op(op), .o_valid(valid), .o_instr(instr));

   csk_skip_core dut_u (.I_CORE_CLK(clk), .I_RESET(rst), .I_HSEL(1'b1), .I_HADDR(haddr),
      .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
      .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(), .I_INSTR_VALID(valid), .I_INSTR(instr),
      .I_EXTERNAL_INTERRUPT_PIN_B(pin), .I_POWERDOWN_FLAG(pd), .I_TIMER1_SET(tset), .O_SKIP(skip),
      .O_DONE(done), .O_SUPPRESSED(supp), .O_TIMER1_REQUEST_FLAG(t1f), .O_IRQ(irq));

   task complete_run;
   begin
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask

   task chk(input [31:0] got, input [31:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask

   task wait_ready;
      integer n;
   begin
      n = 0;
      @(posedge clk);
      while (hready !== 1'b1)
      begin
         n = n + 1;
         if (n > 20)
         begin
            n_mismatch = n_mismatch + 1;
            complete_run;
         end
         @(posedge clk);
      end
   end
   endtask

   task ahb(input w, input [7:0] a, input [31:0] d);
   begin
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_ready;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready;
      r = hrdata;
   end
   endtask

   task exec(input [9:0] o, input [2:0] e);
   begin
      go <= 1'b1;
      op <= o;
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
      chk({skip, done, supp}, e);
   end
   endtask

   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      ahb(0, 8'h00, 0);
      chk(r, 0);
      ahb(1, 8'h04, 32'hF);
      ahb(0, 8'h04, 0);
      chk(r, 32'hF);
      ahb(1, 8'h20, 32'h5);
      ahb(0, 8'h20, 0);
      chk(r, 0);
      $display("test registers done");
      for (p = 0; p < 2; p = p + 1)
         for (v = 0; v < 2; v = v + 1)
         begin
            pin <= v[0];
            ahb(1, 8'h00, p);
            exec(10'h03B, (v == p) ? 3'h6 : 3'h2);
            if (v == p)
               exec(10'h03B, 3'h1);
         end
      chk(irq, 0);
      ahb(0, 8'h0C, 0);
      chk(r, 32'h5);
      ahb(1, 8'h10, 32'h1);
      @(posedge clk);
      chk(irq, 1);
      ahb(1, 8'h0C, 32'h7);
      @(posedge clk);
      chk(irq, 0);
      $display("test pin skip done");
      ahb(1, 8'h04, 32'h4);
      tset <= 1'b1;
      @(posedge clk);
      tset <= 1'b0;
      @(posedge clk);
      chk(t1f, 1);
      exec(10'h280, 3'h2);
      chk(t1f, 1);
      ahb(1, 8'h04, 32'hB);
      exec(10'h280, 3'h6);
      chk(t1f, 0);
      exec(10'h3FF, 3'h1);
      exec(10'h280, 3'h2);
      $display("test timer1 skip done");
      pd <= 1'b1;
      exec(10'h003, 3'h6);
      exec(10'h003, 3'h1);
      ahb(0, 8'h08, 0);
      chk(r[3:2], 2'h1);
      pd <= 1'b0;
      exec(10'h003, 3'h2);
      exec(10'h03A, 3'h0);
      exec(10'h3FF, 3'h0);
      $display("test powerdown skip done");
      complete_run;
   end
endmodule // csk_skip_core_tb

bind csk_skip_core csk_skip_checker chk_u (.*);
